// ### include/fopc_pkg.sv
// Purpose: Constants and types shared by the fault output controller.
// Assumes: System clock of 100 MHz (10 ns period).
// Notes: All timing counts are derived from the clock period in ns.
package fopc_pkg;
  // ************************************************************
  // Clock and timing
  // ************************************************************
  // System clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 10;
  // Blinker period in nanoseconds (1.25 Hz).
  localparam longint BLINK_PERIOD_NS = 800000000;
  // PWM period in nanoseconds (100 Hz).
  localparam longint PWM_PERIOD_NS = 10000000;
  // Blink half period in clock cycles (50 percent duty).
  localparam int BLINK_HALF_CYC = int'(BLINK_PERIOD_NS / (2 * CLK_PERIOD_NS));
  // PWM period in clock cycles.
  localparam int PWM_PERIOD_CYC = int'(PWM_PERIOD_NS / CLK_PERIOD_NS);
  // PWM low time for each duty setting: 20, 10, 5 and 2.5 percent.
  localparam int PWM_ON_20_CYC = PWM_PERIOD_CYC / 5;
  localparam int PWM_ON_10_CYC = PWM_PERIOD_CYC / 10;
  localparam int PWM_ON_5_CYC = PWM_PERIOD_CYC / 20;
  localparam int PWM_ON_2P5_CYC = PWM_PERIOD_CYC / 40;
  // Counter widths.
  localparam int BLINK_CNT_W = 26;
  localparam int PWM_CNT_W = 20;
  // ************************************************************
  // Fault sources and configuration
  // ************************************************************
  // Undervoltage events that trip the fault outputs.
  localparam logic [2:0] UV_TRIP_COUNT = 3'h4;
  // Duty selection reset value (20 percent).
  localparam logic [1:0] DUTY_SEL_RESET = 2'h0;
  // Hardware configuration codes.
  localparam logic [1:0] HW_CFG_1 = 2'h0;
  localparam logic [1:0] HW_CFG_2 = 2'h1;
  localparam logic [1:0] HW_CFG_3 = 2'h2;
  localparam logic [1:0] HW_CFG_4 = 2'h3;
  // Watchdog failure tracking state.
  typedef enum logic [1:0] {FOPC_WD_OK, FOPC_WD_ONE, FOPC_WD_TWO} fopc_wd_e;
endpackage

// ### test/fopc_fault_output_ctrl_tb.sv
// Purpose: Self-checking bench for the fault output controller.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes: Long blink periods are only checked in their first half; PWM only around its first low-to-high edge.
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("wrong value %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module fopc_fault_output_ctrl_tb;
  import fopc_pkg::*;
  // Clock, reset and stimulus.
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  logic thermalShutdownStage2, mainSupplyShort, mainSupplyOv, mainSupplyUvEvent;
  logic mainSupplyUvClear, watchdogFailEvent, watchdogTriggerOk, enterSleep;
  logic watchdogStopDisable, mainSupplyOvResetEnable, faultForceOn, failureFlagClear;
  logic [1:0] hwConfig;
  logic [1:0] faultPwmDutySelect;
  // Observed outputs and resolved pins.
  logic failureFlag, watchdogFailFlag, failSafeRequest;
  logic staticOe, blinkOe, pwmOe, staticPin, blinkPin, pwmPin;
  int checks = 0;
  int miscompares = 0;
  int fsCount = 0;
  int lowCyc;
  // The clock toggles every half period of 5 ns.
  always #5 clk_sys = ~clk_sys;
  // Count cycles with the fail-safe request high.
  always @(posedge clk_sys)
  begin
    if (failSafeRequest === 1'h1)
    begin
      fsCount++;
    end
  end
  fopc_fault_output_ctrl u_fopc_fault_output_ctrl (
    .clk_sys(clk_sys), .nrst(nrst),
    .thermalShutdownStage2(thermalShutdownStage2), .mainSupplyShort(mainSupplyShort),
    .mainSupplyOv(mainSupplyOv), .mainSupplyUvEvent(mainSupplyUvEvent),
    .mainSupplyUvClear(mainSupplyUvClear), .watchdogFailEvent(watchdogFailEvent),
    .watchdogTriggerOk(watchdogTriggerOk), .hwConfig(hwConfig), .enterSleep(enterSleep),
    .watchdogStopDisable(watchdogStopDisable),
    .mainSupplyOvResetEnable(mainSupplyOvResetEnable), .faultForceOn(faultForceOn),
    .faultPwmDutySelect(faultPwmDutySelect), .failureFlagClear(failureFlagClear),
    .failureFlag(failureFlag), .watchdogFailFlag(watchdogFailFlag),
    .failSafeRequest(failSafeRequest),
    .faultStaticIn(staticPin), .faultStaticOut(), .faultStaticOe(staticOe),
    .faultBlinkIn(blinkPin), .faultBlinkOut(), .faultBlinkOe(blinkOe),
    .faultDimmedPwmIn(pwmPin), .faultDimmedPwmOut(), .faultDimmedPwmOe(pwmOe)
  );
  fopc_lamp_model u_fopc_lamp_model (
    .staticOe(staticOe), .blinkOe(blinkOe), .pwmOe(pwmOe),
    .staticPin(staticPin), .blinkPin(blinkPin), .pwmPin(pwmPin)
  );
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Waits n rising edges, then steps off the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Pulses one event input for a single cycle.
  task automatic fire(input int k);
    case (k)
      0: watchdogFailEvent = 1'h1;
      1: watchdogTriggerOk = 1'h1;
      2: mainSupplyUvEvent = 1'h1;
      3: failureFlagClear = 1'h1;
      4: enterSleep = 1'h1;
      5: watchdogStopDisable = 1'h1;
      default: mainSupplyUvClear = 1'h1;
    endcase
    tick(1);
    {watchdogFailEvent, watchdogTriggerOk, mainSupplyUvEvent, failureFlagClear} = 4'h0;
    {enterSleep, watchdogStopDisable, mainSupplyUvClear} = 3'h0;
    tick(1);
  endtask
  // Waits a bounded time for the static pin, then checks all pins together.
  task automatic wait_pins(input logic exp);
    for (int i = 0; i < 8 && staticPin !== exp; i++)
    begin
      tick(1);
    end
    `CHK("static pin", exp, staticPin)
    `CHK("blink pin", exp, blinkPin)
    `CHK("pwm pin", exp, pwmPin)
    if (staticPin !== exp)
    begin
      wrap_up();
    end
  endtask
  // Waits five cycles, then checks that nothing is lit.
  task automatic stay_idle();
    tick(5);
    `CHK("idle pins", 3'h7, {staticPin, blinkPin, pwmPin})
  endtask
  // Clears the fail-active flag and expects release.
  task automatic release_all();
    fire(3);
    wait_pins(1'h1);
    `CHK("flag after release", 1'h0, failureFlag)
  endtask
  // Main sequence.
  initial
  begin
    {thermalShutdownStage2, mainSupplyShort, mainSupplyOv, mainSupplyUvEvent} = 4'h0;
    {mainSupplyUvClear, watchdogFailEvent, watchdogTriggerOk, enterSleep} = 4'h0;
    {watchdogStopDisable, mainSupplyOvResetEnable, faultForceOn, failureFlagClear} = 4'h0;
    hwConfig = HW_CFG_1;
    faultPwmDutySelect = DUTY_SEL_RESET;
    tick(10);
    nrst = 1'h1;
    `CHK("pins after reset", 3'h7, {staticPin, blinkPin, pwmPin})
    `CHK("flag after reset", 1'h0, failureFlag)
    $display("test reset done");
    for (int k = 0; k < 2; k++)
    begin
      thermalShutdownStage2 = (k == 0);
      mainSupplyShort = (k == 1);
      lowCyc = fsCount;
      wait_pins(1'h0);
      `CHK("fail flag", 1'h1, failureFlag)
      `CHK("fail-safe pulse", 1'h1, fsCount > lowCyc)
      fire(3);
      tick(3);
      `CHK("held while fault", 1'h0, staticPin)
      {thermalShutdownStage2, mainSupplyShort} = 2'h0;
      release_all();
    end
    $display("test thermal and short done");
    mainSupplyOv = 1'h1;
    stay_idle();
    mainSupplyOvResetEnable = 1'h1;
    wait_pins(1'h0);
    {mainSupplyOv, mainSupplyOvResetEnable} = 2'h0;
    release_all();
    repeat (3) fire(2);
    stay_idle();
    fire(2);
    wait_pins(1'h0);
    fire(6);
    release_all();
    $display("test supply done");
    hwConfig = HW_CFG_3;
    fire(0);
    stay_idle();
    fire(0);
    wait_pins(1'h0);
    `CHK("wd flag", 1'h1, watchdogFailFlag)
    fire(3);
    tick(3);
    `CHK("held until trigger", 1'h0, staticPin)
    fire(1);
    release_all();
    hwConfig = HW_CFG_2;
    lowCyc = fsCount;
    fire(0);
    wait_pins(1'h0);
    `CHK("cfg2 fail flag", 1'h0, failureFlag)
    `CHK("cfg2 fail-safe pulse", 1'h0, fsCount > lowCyc)
    fire(4);
    `CHK("wd flag after sleep", 1'h0, watchdogFailFlag)
    release_all();
    hwConfig = HW_CFG_1;
    lowCyc = fsCount;
    fire(0);
    wait_pins(1'h0);
    `CHK("cfg1 fail-safe pulse", 1'h1, fsCount > lowCyc)
    fire(5);
    `CHK("wd flag after stop", 1'h0, watchdogFailFlag)
    release_all();
    $display("test watchdog done");
    faultForceOn = 1'h1;
    wait_pins(1'h0);
    `CHK("flag under force", 1'h0, failureFlag)
    faultForceOn = 1'h0;
    wait_pins(1'h1);
    for (int d = 3; d > 1; d--)
    begin
      faultPwmDutySelect = d[1:0];
      lowCyc = (d == 3) ? PWM_PERIOD_CYC / 40 : PWM_PERIOD_CYC / 20;
      faultForceOn = 1'h1;
      wait_pins(1'h0);
      tick(lowCyc - 8);
      `CHK("pwm low phase", 1'h0, pwmPin)
      tick(16);
      `CHK("pwm high phase", 1'h1, pwmPin)
      `CHK("blink first half", 1'h0, blinkPin)
      `CHK("static held", 1'h0, staticPin)
      // The longer duty settings pull the pin low again at this count.
      faultPwmDutySelect = 2'h1;
      tick(3);
      `CHK("pwm low at 10 percent", 1'h0, pwmPin)
      faultPwmDutySelect = 2'h0;
      tick(3);
      `CHK("pwm low at 20 percent", 1'h0, pwmPin)
      faultForceOn = 1'h0;
      wait_pins(1'h1);
    end
    $display("test duty done");
    // A reset in mid-run releases the pins at once.
    faultForceOn = 1'h1;
    wait_pins(1'h0);
    nrst = 1'h0;
    faultForceOn = 1'h0;
    #1;
    `CHK("pins in reset", 3'h7, {staticPin, blinkPin, pwmPin})
    tick(2);
    nrst = 1'h1;
    stay_idle();
    `CHK("flag after second reset", 1'h0, failureFlag)
    $display("test mid-run reset done");
    wrap_up();
  end
  // Cuts a hung run short.
  initial
  begin
    #1000000;
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire

// ### test/fopc_lamp_model.sv
// Purpose: Lamp loads on the three open-drain fault pins.
// Assumes: Each pin has an external pull-up to the lamp supply.
// Notes: Output enable low means the device sinks the pin.
`timescale 1ns/10ps
`default_nettype none
module fopc_lamp_model (
  // Output enables from the device.
  input wire logic staticOe,
  input wire logic blinkOe,
  input wire logic pwmOe,
  // Resolved pin levels.
  output logic staticPin,
  output logic blinkPin,
  output logic pwmPin
);
  // The pull-up wins unless the device sinks the pin, so low means lamp on.
  assign staticPin = staticOe ? 1'h1 : 1'h0;
  assign blinkPin = blinkOe ? 1'h1 : 1'h0;
  assign pwmPin = pwmOe ? 1'h1 : 1'h0;
endmodule
`default_nettype wire

// ### verilog/fopc_fault_output_ctrl.sv
// Purpose: Fault output controller driving three active-low open-drain lamps.
// Assumes: All inputs synchronous to clk_sys; fault inputs are levels, events are pulses.
// Notes: Open-drain pins: output enable low means the pin is pulled low.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// [R1] Three open-drain active-low fault outputs.
// [R2] Thermal stage two and supply short activate.
// [R3] Watchdog: first fail cfg1/2, second cfg3/4.
// [R4] Overvoltage activates only with reset enable.
// [R5] Four consecutive undervoltage events activate.
// [R6] Fail-safe entry, watchdog depends on config.
// [R7] Fail-active flag set on failure activation.
// [R8] Software force-on drives all outputs.
// [R9] Force-on leaves failure flags untouched.
// [R10] Clearing force-on releases without watchdog trigger.
// [R11] Release needs no fault and flag cleared.
// [R12] Controller triggers watchdog, then clears flag.
// [R13] Watchdog flag clears on sleep, failsafe, stop-disable.
// [R14] Config 2 first watchdog fail sets no flag.
// [R15] All outputs activate together, own waveforms.
// [R16] Static output held low while active.
// [R17] Blink output 1.25 Hz, 50 percent.
// [R18] PWM output 100 Hz, 20 percent default.
// [R19] Duty select 20/10/5/2.5, reset 20.
// [R20] Counters on clock; reset leaves outputs inactive.
module fopc_fault_output_ctrl (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Fault sources.
  input wire logic thermalShutdownStage2,
  input wire logic mainSupplyShort,
  input wire logic mainSupplyOv,
  input wire logic mainSupplyUvEvent,
  input wire logic mainSupplyUvClear,
  input wire logic watchdogFailEvent,
  input wire logic watchdogTriggerOk,
  // Device mode and configuration.
  input wire logic [1:0] hwConfig,
  input wire logic enterSleep,
  input wire logic watchdogStopDisable,
  // Software controls.
  input wire logic mainSupplyOvResetEnable,
  input wire logic faultForceOn,
  input wire logic [1:0] faultPwmDutySelect,
  input wire logic failureFlagClear,
  // Status.
  output logic failureFlag,
  output logic watchdogFailFlag,
  output logic failSafeRequest,
  // Open-drain pins: input, output and output enable (low means driven low).
  input wire logic faultStaticIn,
  output logic faultStaticOut,
  output logic faultStaticOe,
  input wire logic faultBlinkIn,
  output logic faultBlinkOut,
  output logic faultBlinkOe,
  input wire logic faultDimmedPwmIn,
  output logic faultDimmedPwmOut,
  output logic faultDimmedPwmOe
);
  import fopc_pkg::*;

  // ************************************************************
  // Functions
  // ************************************************************
  // Maps the duty selection to the PWM low time in cycles.
  function automatic logic [PWM_CNT_W-1:0] dutyCycles(input logic [1:0] sel);
    case (sel)
      2'h0: dutyCycles = PWM_CNT_W'(PWM_ON_20_CYC);
      2'h1: dutyCycles = PWM_CNT_W'(PWM_ON_10_CYC);
      2'h2: dutyCycles = PWM_CNT_W'(PWM_ON_5_CYC);
      default: dutyCycles = PWM_CNT_W'(PWM_ON_2P5_CYC);
    endcase
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  fopc_wd_e wdState; // Watchdog failure history.
  fopc_wd_e next_wdState;
  logic [2:0] uvCount; // Consecutive undervoltage count.
  logic [2:0] next_uvCount;
  logic failureLatched; // Failure-derived activation held until released.
  logic next_failureLatched;
  logic next_failureFlag;
  logic next_watchdogFailFlag;
  logic next_failSafeRequest;
  logic [1:0] dutySel; // Registered duty selection.
  logic [1:0] next_dutySel;
  logic [BLINK_CNT_W-1:0] blinkCnt; // Blink half-period counter.
  logic [BLINK_CNT_W-1:0] next_blinkCnt;
  logic blinkPhase; // High means blink pin pulled low.
  logic next_blinkPhase;
  logic [PWM_CNT_W-1:0] pwmCnt; // PWM period counter.
  logic [PWM_CNT_W-1:0] next_pwmCnt;
  logic outActive; // Registered combined activation.
  logic next_outActive;
  logic pwmLow; // Registered PWM low phase.
  logic next_pwmLow;

  // Combinational helpers.
  logic wdTrip; // Watchdog failure that activates outputs.
  logic wdSetsFlag; // Watchdog failure that sets the failure flag.
  logic otherFault; // Non-watchdog failure condition present.
  logic faultPresent; // Any failure condition still present.
  logic failEvent; // A failure activates outputs this cycle.

  // ************************************************************
  // Fault collection
  // ************************************************************
  // Decides which failures activate the outputs and set the flags.
  always_comb
  begin
    next_wdState = wdState;
    next_uvCount = uvCount;
    wdTrip = 1'b0;
    wdSetsFlag = 1'b0;
    // Watchdog failure counting per hardware configuration.
    if (watchdogFailEvent)
    begin
      if (hwConfig == HW_CFG_1 || hwConfig == HW_CFG_2)
      begin
        wdTrip = 1'b1; // [R3]
        // Configuration 2 first failure leaves the flag alone.
        wdSetsFlag = !(hwConfig == HW_CFG_2 && wdState == FOPC_WD_OK); // [R14]
      end
      else
      begin
        wdTrip = (wdState != FOPC_WD_OK); // [R3]
        wdSetsFlag = wdTrip;
      end
      next_wdState = (wdState == FOPC_WD_OK) ? FOPC_WD_ONE : FOPC_WD_TWO;
    end
    else if (watchdogTriggerOk)
    begin
      next_wdState = FOPC_WD_OK; // A good trigger ends the consecutive run.
    end
    // Undervoltage event counter; saturates at the trip count.
    if (mainSupplyUvClear)
    begin
      next_uvCount = 3'h0;
    end
    else if (mainSupplyUvEvent && uvCount != UV_TRIP_COUNT)
    begin
      next_uvCount = uvCount + 3'h1;
    end
    otherFault = thermalShutdownStage2 || mainSupplyShort // [R2]
      || (mainSupplyOv && mainSupplyOvResetEnable) // [R4]
      || (uvCount == UV_TRIP_COUNT); // [R5]
    faultPresent = otherFault || watchdogFailFlag;
    failEvent = otherFault || wdTrip;
  end

  // Flags and latched activation; set wins over any clear.
  always_comb
  begin
    next_failureLatched = failureLatched;
    next_failureFlag = failureFlag;
    next_watchdogFailFlag = watchdogFailFlag;
    next_failSafeRequest = 1'b0;
    // Watchdog flag clears on good trigger, sleep, stop-disable or other failure.
    if (watchdogTriggerOk || enterSleep || watchdogStopDisable || otherFault) // [R13] [R12]
    begin
      next_watchdogFailFlag = 1'b0;
    end
    if (wdTrip)
    begin
      next_watchdogFailFlag = 1'b1;
    end
    // Software clear only releases when no failure remains.
    if (failureFlagClear && !faultPresent && !wdTrip) // [R11]
    begin
      next_failureFlag = 1'b0;
      next_failureLatched = 1'b0;
    end
    if (failEvent)
    begin
      next_failureLatched = 1'b1;
      // Flag reports activation except configuration 2 first watchdog failure.
      if (otherFault || wdSetsFlag)
      begin
        next_failureFlag = 1'b1; // [R7]
      end
      // Fail-safe on other failures; watchdog only in configurations 1 and 3.
      next_failSafeRequest = otherFault
        || (hwConfig == HW_CFG_1 || hwConfig == HW_CFG_3); // [R6]
    end
  end

  // ************************************************************
  // Waveform generation
  // ************************************************************
  // Blink and PWM counters run only while active, held at zero otherwise; force-on does not touch flags.
  always_comb
  begin
    next_outActive = failureLatched || faultForceOn; // [R8] [R9] [R10] [R15]
    next_dutySel = faultPwmDutySelect; // [R19]
    next_blinkCnt = blinkCnt;
    next_blinkPhase = blinkPhase;
    next_pwmCnt = pwmCnt;
    if (!outActive)
    begin
      // Restart waveforms so all pins start low together.
      next_blinkCnt = '0;
      next_blinkPhase = 1'b1;
      next_pwmCnt = '0;
    end
    else
    begin
      if (blinkCnt == BLINK_CNT_W'(BLINK_HALF_CYC - 1)) // [R17] [R20]
      begin
        next_blinkCnt = '0;
        next_blinkPhase = !blinkPhase;
      end
      else
      begin
        next_blinkCnt = blinkCnt + BLINK_CNT_W'(1);
      end
      next_pwmCnt = (pwmCnt == PWM_CNT_W'(PWM_PERIOD_CYC - 1)) ? '0 // [R18] [R20]
        : pwmCnt + PWM_CNT_W'(1);
    end
    // The registered selection is used, so a new duty applies one cycle later.
    next_pwmLow = next_outActive && (next_pwmCnt < dutyCycles(dutySel)); // [R18] [R19]
  end

  // Registers every group of state.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      wdState <= FOPC_WD_OK;
      uvCount <= 3'h0;
      failureLatched <= 1'b0; // [R20]
      failureFlag <= 1'b0;
      watchdogFailFlag <= 1'b0;
      failSafeRequest <= 1'b0;
      dutySel <= DUTY_SEL_RESET; // [R19]
      blinkCnt <= '0;
      blinkPhase <= 1'b1;
      pwmCnt <= '0;
      outActive <= 1'b0;
      pwmLow <= 1'b0;
    end
    else
    begin
      wdState <= next_wdState;
      uvCount <= next_uvCount;
      failureLatched <= next_failureLatched;
      failureFlag <= next_failureFlag;
      watchdogFailFlag <= next_watchdogFailFlag;
      failSafeRequest <= next_failSafeRequest;
      dutySel <= next_dutySel;
      blinkCnt <= next_blinkCnt;
      blinkPhase <= next_blinkPhase;
      pwmCnt <= next_pwmCnt;
      outActive <= next_outActive;
      pwmLow <= next_pwmLow;
    end
  end

  // ************************************************************
  // Pin drive
  // ************************************************************
  // Outputs always drive zero; enable low pulls the pin low.
  assign faultStaticOut = 1'b0;
  assign faultBlinkOut = 1'b0;
  assign faultDimmedPwmOut = 1'b0;
  assign faultStaticOe = !outActive; // [R1] [R16]
  assign faultBlinkOe = !(outActive && blinkPhase); // [R1] [R17]
  assign faultDimmedPwmOe = !pwmLow; // [R1] [R18]

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_tsd;
    thermalShutdownStage2;
  endsequence
  sequence s_active2;
    ##2 outActive;
  endsequence
  property p_tsdActivates;
    @(posedge clk_sys) disable iff (!nrst) s_tsd |-> s_active2;
  endproperty
  a_tsdActivates: assert property (p_tsdActivates) else $error("Thermal fault not shown."); // [R2]
  property p_ovGated;
    @(posedge clk_sys) disable iff (!nrst)
      (mainSupplyOv && !mainSupplyOvResetEnable && !failureLatched && !faultForceOn
       && !thermalShutdownStage2 && !mainSupplyShort && uvCount != 3'h4 && !watchdogFailEvent)
      |=> !failureLatched;
  endproperty
  a_ovGated: assert property (p_ovGated) else $error("Overvoltage drove outputs."); // [R4]
  property p_uvFour;
    @(posedge clk_sys) disable iff (!nrst) (uvCount == 3'h4) |=> failureLatched;
  endproperty
  a_uvFour: assert property (p_uvFour) else $error("Undervoltage count ignored."); // [R5]
  property p_cfg2First;
    @(posedge clk_sys) disable iff (!nrst)
      (watchdogFailEvent && hwConfig == 2'h1 && wdState == FOPC_WD_OK && !failureFlag
       && !thermalShutdownStage2 && !mainSupplyShort && !mainSupplyOv && uvCount != 3'h4)
      |=> !failureFlag && failureLatched;
  endproperty
  a_cfg2First: assert property (p_cfg2First) else $error("Config 2 flag set early."); // [R14]
  property p_cfg3First;
    @(posedge clk_sys) disable iff (!nrst)
      (watchdogFailEvent && hwConfig == 2'h2 && wdState == FOPC_WD_OK && !failureLatched
       && !thermalShutdownStage2 && !mainSupplyShort && !mainSupplyOv && uvCount != 3'h4)
      |=> !failureLatched;
  endproperty
  a_cfg3First: assert property (p_cfg3First) else $error("Config 3 tripped early."); // [R3]
  property p_forceOn;
    @(posedge clk_sys) disable iff (!nrst) faultForceOn |=> !faultStaticOe;
  endproperty
  a_forceOn: assert property (p_forceOn) else $error("Force-on not applied."); // [R8]
  property p_forceNoFlag;
    @(posedge clk_sys) disable iff (!nrst) $rose(faultForceOn) && !failureFlag
      && !thermalShutdownStage2 && !mainSupplyShort && !mainSupplyOv && uvCount != 3'h4
      && !watchdogFailEvent |=> !failureFlag;
  endproperty
  a_forceNoFlag: assert property (p_forceNoFlag) else $error("Force-on set flag."); // [R9]
  property p_sleepClear;
    @(posedge clk_sys) disable iff (!nrst) (enterSleep && !watchdogFailEvent) |=> !watchdogFailFlag;
  endproperty
  a_sleepClear: assert property (p_sleepClear) else $error("Watchdog flag kept."); // [R13]
  property p_holdLatched;
    @(posedge clk_sys) disable iff (!nrst)
      (failureLatched && faultPresent) |=> failureLatched;
  endproperty
  a_holdLatched: assert property (p_holdLatched) else $error("Released with fault."); // [R11]
  property p_together;
    @(posedge clk_sys) disable iff (!nrst) $rose(outActive) |->
      (!faultStaticOe && !faultBlinkOe && !faultDimmedPwmOe);
  endproperty
  a_together: assert property (p_together) else $error("Outputs not together."); // [R15]
endmodule
`default_nettype wire
